// [dv/hdlbc_link_model.sv]
// Far-end link model: consumes one unit per pulse while the transmit engine is sending
`timescale 1ns/1ps
module hdlbc_link_model (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_n,
  // Engine state and pacing
  input wire logic i_sending,
  input wire logic [3:0] i_gap,
  // Link side
  output logic o_unit_done,
  output int o_units
);
  logic [3:0] wait_ff;
  ////////////////////////////////////////////////////////////////////////////////
  // Pulses stay still between transfers when i_gap is 2 or more; no pulse directly follows a pulse, which keeps the done cycle free of pulses
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      o_unit_done <= 1'b0;
      o_units <= 0;
      wait_ff <= 4'h0;
    end else begin
      o_unit_done <= 1'b0;
      if (i_sending && wait_ff >= i_gap && !o_unit_done) begin
        o_unit_done <= 1'b1;
        o_units <= o_units + 1;
        wait_ff <= 4'h0;
      end else if (i_sending) begin
        wait_ff <= wait_ff + 4'h1;
      end else begin
        wait_ff <= 4'h0;
      end
    end
  end
endmodule : hdlbc_link_model

// [dv/hdlc_link_buffer_count_control_test.sv]
// Self-checking bench of the data-link buffer select and count control
`timescale 1ns/1ps
`include "hdlbc_cfg.svh"
module hdlc_link_buffer_count_control_test;
  logic i_mclk = 1'b0;
  logic i_rst_n = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [11:0] adr = 12'h000;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] rdat;
  logic ack, irq, sending, tx_buf, tx_mos, rx_mos, rx_ptr, unit_done;
  logic [15:0] rd_addr;
  hdlbc_pkg::hdlbc_cnt_t rx_len;
  hdlbc_pkg::hdlbc_rx_evt_s rx_evt = '0;
  logic [3:0] gap = 4'h2;
  logic [7:0] q;
  int units, u0;
  int mismatches = 0;
  int num_checks = 0;
  always #5 i_mclk = ~i_mclk;
  hdlbc_top hdlbc_top_i (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_wb_cyc(cyc), .i_wb_stb(stb),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat),
    .o_wb_ack(ack), .o_irq(irq), .i_tx_unit_done(unit_done), .o_tx_sending(sending),
    .o_tx_buf(tx_buf), .o_tx_mos(tx_mos), .o_tx_rd_addr(rd_addr), .i_rx_evt(rx_evt),
    .o_rx_mos(rx_mos), .o_rx_ptr(rx_ptr), .o_rx_len(rx_len));
  hdlbc_link_model hdlbc_link_model_i (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_sending(sending),
    .i_gap(gap), .o_unit_done(unit_done), .o_units(units));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [9:0] idx, input logic [7:0] d);
    @(posedge i_mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= 4'hf;
    adr <= {idx, 2'b00};
    wdat <= {24'h00_0000, d};
    do begin
      @(posedge i_mclk);
    end while (ack !== 1'b1);
    q = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : wb
  task automatic rd(input string what, input logic [9:0] idx, input logic [7:0] exp);
    wb(1'b0, idx, 8'h00);
    chk(what, {24'h00_0000, q}, {24'h00_0000, exp});
  endtask : rd
  task automatic clk(input int n);
    repeat (n) @(posedge i_mclk);
  endtask : clk
  task automatic wait_idle();
    clk(3);
    while (sending !== 1'b0) begin
      clk(1);
    end
    clk(3);
  endtask : wait_idle
  task automatic rx_pulse(input logic dn, input logic p, input logic [6:0] b, input logic r);
    @(posedge i_mclk);
    rx_evt <= '{done: dn, buf_ptr: p, bytes: b, repeat_seen: r};
    @(posedge i_mclk);
    rx_evt <= '0;
    clk(3);
  endtask : rx_pulse
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rd("next free", `HDLBC_IDX_TXCNT, 8'h80);
    rd("rx count", `HDLBC_IDX_RXCNT, 8'h00);
    rd("status", `HDLBC_IDX_ISTS, 8'h00);
    rd("mask", `HDLBC_IDX_IMSK, 8'h00);
    wb(1'b1, 10'h3ff, 8'hff);
    rd("unmapped", 10'h3ff, 8'h00);
    chk("irq", irq, 1'b0);
    $display("test reset done");
  endtask : t_reset
  task automatic t_bos();
    wb(1'b1, `HDLBC_IDX_TXCTL, 8'h00);
    u0 = units;
    wb(1'b1, `HDLBC_IDX_TXCNT, 8'h03);
    clk(3);
    chk("sending", sending, 1'b1);
    chk("tx buf", tx_buf, 1'b0);
    chk("tx mode", tx_mos, 1'b0);
    rd("free while busy", `HDLBC_IDX_TXCNT, 8'h83);
    wait_idle();
    chk("bos reps", units - u0, 3);
    rd("tx end", `HDLBC_IDX_ISTS, 8'h01);
    chk("irq masked", irq, 1'b0);
    wb(1'b1, `HDLBC_IDX_IMSK, 8'h03);
    clk(2);
    chk("irq on", irq, 1'b1);
    wb(1'b1, `HDLBC_IDX_ISTS, 8'h01);
    clk(2);
    chk("irq off", irq, 1'b0);
    rd("cleared", `HDLBC_IDX_ISTS, 8'h00);
    $display("test bos done");
  endtask : t_bos
  task automatic t_mos();
    gap <= 4'h6;
    wb(1'b1, `HDLBC_IDX_TXCTL, 8'h01);
    rd("tx mode reg", `HDLBC_IDX_TXCTL, 8'h01);
    u0 = units;
    wb(1'b1, `HDLBC_IDX_TXCNT, 8'h85);
    clk(3);
    chk("tx mode", tx_mos, 1'b1);
    chk("tx buf", tx_buf, 1'b1);
    rd("free while busy", `HDLBC_IDX_TXCNT, 8'h05);
    wait_idle();
    chk("octets", units - u0, 5);
    chk("read addr", rd_addr, 16'h0705);
    rd("tx end", `HDLBC_IDX_ISTS, 8'h01);
    wb(1'b1, `HDLBC_IDX_ISTS, 8'h01);
    rd("next free", `HDLBC_IDX_TXCNT, 8'h05);
    u0 = units;
    wb(1'b1, `HDLBC_IDX_TXCNT, 8'h00);
    wait_idle();
    chk("empty message", units - u0, 0);
    rd("empty end", `HDLBC_IDX_ISTS, 8'h01);
    wb(1'b1, `HDLBC_IDX_ISTS, 8'h01);
    gap <= 4'h2;
    $display("test mos done");
  endtask : t_mos
  task automatic t_inf();
    wb(1'b1, `HDLBC_IDX_TXCTL, 8'h00);
    wb(1'b1, `HDLBC_IDX_TXCNT, 8'h00);
    clk(60);
    chk("endless", sending, 1'b1);
    rd("no end", `HDLBC_IDX_ISTS, 8'h00);
    wb(1'b1, `HDLBC_IDX_TXCNT, 8'h81);
    wait_idle();
    chk("tx buf", tx_buf, 1'b1);
    rd("tx end", `HDLBC_IDX_ISTS, 8'h01);
    wb(1'b1, `HDLBC_IDX_ISTS, 8'h01);
    $display("test endless done");
  endtask : t_inf
  task automatic t_rx();
    wb(1'b1, `HDLBC_IDX_RXCTL, 8'h01);
    rx_pulse(1'b1, 1'b1, 7'h09, 1'b0);
    chk("rx ptr", rx_ptr, 1'b1);
    chk("rx mode", rx_mos, 1'b1);
    rd("rx mode reg", `HDLBC_IDX_RXCTL, 8'h01);
    chk("rx len", rx_len, 7'h09);
    rd("rx count", `HDLBC_IDX_RXCNT, 8'h89);
    rd("rx end", `HDLBC_IDX_ISTS, 8'h02);
    chk("irq rx", irq, 1'b1);
    wb(1'b1, `HDLBC_IDX_ISTS, 8'h02);
    rx_pulse(1'b1, 1'b0, 7'h7f, 1'b0);
    rd("rx count max", `HDLBC_IDX_RXCNT, 8'h7f);
    wb(1'b1, `HDLBC_IDX_ISTS, 8'h02);
    wb(1'b1, `HDLBC_IDX_RXCTL, 8'h00);
    wb(1'b1, `HDLBC_IDX_RXCNT, 8'h02);
    rx_pulse(1'b0, 1'b0, 7'h00, 1'b1);
    rd("one of two", `HDLBC_IDX_ISTS, 8'h00);
    rx_pulse(1'b0, 1'b0, 7'h00, 1'b1);
    rd("two of two", `HDLBC_IDX_ISTS, 8'h02);
    wb(1'b1, `HDLBC_IDX_ISTS, 8'h02);
    rx_pulse(1'b1, 1'b1, 7'h05, 1'b0);
    rd("bos pointer", `HDLBC_IDX_RXCNT, 8'h82);
    wb(1'b1, `HDLBC_IDX_RXCNT, 8'h00);
    repeat (5) rx_pulse(1'b0, 1'b0, 7'h00, 1'b1);
    rd("endless rx", `HDLBC_IDX_ISTS, 8'h00);
    $display("test receive done");
  endtask : t_rx
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : conclude
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #300us;
    mismatches++;
    $display("mismatch watchdog expected finish seen hang");
    conclude();
  end
  initial begin
    clk(5);
    i_rst_n <= 1'b1;
    t_reset();
    t_bos();
    t_mos();
    t_inf();
    t_rx();
    conclude();
  end
endmodule : hdlc_link_buffer_count_control_test

// [hdl/hdlbc_cfg.svh]
// Constants of the data-link buffer and count control
`ifndef HDLBC_CFG_SVH
`define HDLBC_CFG_SVH
`define HDLBC_CNT_W 7
`define HDLBC_CNT_ZERO 7'h00
`define HDLBC_CNT_ONE 7'h01
`define HDLBC_SEL_BIT 7
`define HDLBC_MODE_BIT 0
`define HDLBC_ADR_W 12
`define HDLBC_IDX_W 10
`define HDLBC_IDX_TXCTL 10'h140
`define HDLBC_IDX_RXCTL 10'h141
`define HDLBC_IDX_TXCNT 10'h144
`define HDLBC_IDX_RXCNT 10'h145
`define HDLBC_IDX_ISTS 10'h146
`define HDLBC_IDX_IMSK 10'h147
`define HDLBC_IRQ_W 2
`define HDLBC_IRQ_TX 0
`define HDLBC_IRQ_RX 1
`define HDLBC_IRQ_RST 2'h0
`define HDLBC_BADR_W 16
`define HDLBC_BUF0_BASE 16'h0600
`define HDLBC_BUF1_BASE 16'h0700
`define HDLBC_ADR_PAD 9'h000
`define HDLBC_DAT_W 32
`define HDLBC_DAT_ZERO 32'h0000_0000
`endif

// [hdl/hdlbc_pkg.sv]
// Shared types of the data-link buffer and count control
`include "hdlbc_cfg.svh"
package hdlbc_pkg;
  typedef logic [`HDLBC_CNT_W-1:0] hdlbc_cnt_t;
  typedef enum logic [1:0] {TX_IDLE = 2'b00, TX_RUN = 2'b01, TX_DONE = 2'b11} hdlbc_tx_e;
  typedef struct packed {
    logic start; logic buf_sel; hdlbc_cnt_t count; logic message_oriented_signalling;
  } hdlbc_tx_cmd_s;
  typedef struct packed {
    logic active; logic busy_buf; logic last_buf; logic eot; logic message_oriented_signalling;
    logic [`HDLBC_BADR_W-1:0] rd_addr;
  } hdlbc_tx_stat_s;
  typedef struct packed {
    logic done; logic buf_ptr; hdlbc_cnt_t bytes; logic repeat_seen;
  } hdlbc_rx_evt_s;
  typedef struct packed {logic ptr; hdlbc_cnt_t len; logic eot;} hdlbc_rx_stat_s;
  typedef struct packed {
    hdlbc_tx_e fsm; logic active; logic busy_buf; logic last_buf; hdlbc_cnt_t cnt;
    hdlbc_cnt_t sent; logic message_oriented_signalling; logic infinite; logic pend; logic pend_buf;
    hdlbc_cnt_t pend_cnt; logic pend_mos; logic [`HDLBC_BADR_W-1:0] rd_addr;
  } hdlbc_tx_st_s;
  typedef struct packed {logic ptr; hdlbc_cnt_t len; hdlbc_cnt_t reps; logic eot;} hdlbc_rx_st_s;
  typedef struct packed {
    logic ack; logic [`HDLBC_DAT_W-1:0] rdat; logic tx_mos; logic rx_mos;
    hdlbc_cnt_t tx_cnt; logic tx_sel; logic tx_start;
    logic [`HDLBC_IRQ_W-1:0] sts; logic [`HDLBC_IRQ_W-1:0] msk; logic irq;
  } hdlbc_top_st_s;
endpackage : hdlbc_pkg

// [hdl/hdlbc_rx_ctrl.sv]
// Receive buffer pointer, length and repetition counting
`timescale 1ns/1ps
`include "hdlbc_cfg.svh"
module hdlbc_rx_ctrl (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_n,
  // Mode, software write, receiver events
  input wire logic i_mos,
  input wire logic i_sw_wr,
  input wire logic i_sw_ptr,
  input wire hdlbc_pkg::hdlbc_cnt_t i_sw_cnt,
  input wire hdlbc_pkg::hdlbc_rx_evt_s i_evt,
  // Status
  output hdlbc_pkg::hdlbc_rx_stat_s o_stat
);
  hdlbc_pkg::hdlbc_rx_st_s st_ff, nxt;
  always_comb begin
    nxt = st_ff;
    nxt.eot = 1'b0;
    if (i_sw_wr) begin
      nxt.ptr = i_sw_ptr;
      nxt.len = i_sw_cnt;
      nxt.reps = `HDLBC_CNT_ZERO;
    end
    if (!i_mos && i_evt.repeat_seen && st_ff.len != `HDLBC_CNT_ZERO) begin
      nxt.reps = st_ff.reps + `HDLBC_CNT_ONE;
      if (nxt.reps == st_ff.len) begin
        nxt.eot = 1'b1;
        nxt.reps = `HDLBC_CNT_ZERO;
      end
    end
    if (i_evt.done) begin
      nxt.ptr = i_evt.buf_ptr;
      if (i_mos) begin
        nxt.len = i_evt.bytes;
        nxt.eot = 1'b1;
      end
    end
  end
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt;
    end
  end
  assign o_stat = '{ptr: st_ff.ptr, len: st_ff.len, eot: st_ff.eot};
  a_rx_rep_end: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n)
    (!i_mos && i_evt.repeat_seen && !i_sw_wr && st_ff.len != `HDLBC_CNT_ZERO
     && st_ff.reps + `HDLBC_CNT_ONE == st_ff.len) |=> st_ff.eot && st_ff.reps == `HDLBC_CNT_ZERO)
    else $error("rx repeat count reached without end event");
endmodule : hdlbc_rx_ctrl

// [hdl/hdlbc_top.sv]
// Data-link buffer select and count control with Wishbone registers
`timescale 1ns/1ps
`include "hdlbc_cfg.svh"
module hdlbc_top (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_n,
  // Wishbone slave
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [`HDLBC_ADR_W-1:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [`HDLBC_DAT_W-1:0] i_wb_dat,
  output logic [`HDLBC_DAT_W-1:0] o_wb_dat,
  output logic o_wb_ack,
  // Interrupt
  output logic o_irq,
  // Transmit controller side
  input wire logic i_tx_unit_done,
  output logic o_tx_sending,
  output logic o_tx_buf,
  output logic o_tx_mos,
  output logic [`HDLBC_BADR_W-1:0] o_tx_rd_addr,
  // Receive controller side
  input wire hdlbc_pkg::hdlbc_rx_evt_s i_rx_evt,
  output logic o_rx_mos,
  output logic o_rx_ptr,
  output hdlbc_pkg::hdlbc_cnt_t o_rx_len
);

////////////////////////////////////////////////////////////////////////////////

  hdlbc_pkg::hdlbc_top_st_s st_ff;
  hdlbc_pkg::hdlbc_top_st_s nxt;
  hdlbc_pkg::hdlbc_tx_cmd_s tx_cmd;
  hdlbc_pkg::hdlbc_tx_stat_s tx_stat;
  hdlbc_pkg::hdlbc_rx_stat_s rx_stat;
  logic [`HDLBC_IDX_W-1:0] idx;
  logic req;
  logic rd_req;
  logic wr;
  logic rx_wr;
  logic next_free;
  logic [`HDLBC_DAT_W-1:0] rdat;
  logic [`HDLBC_IRQ_W-1:0] evt;
  logic [`HDLBC_IRQ_W-1:0] clr;

  assign idx = i_wb_adr[`HDLBC_ADR_W-1:2];
  assign req = i_wb_cyc && i_wb_stb;
  assign rd_req = req && !i_wb_we && !st_ff.ack;
  // Writes land at the edge where the master samples ack
  assign wr = req && i_wb_we && st_ff.ack && i_wb_sel[0];
  assign rx_wr = wr && idx == `HDLBC_IDX_RXCNT;

////////////////////////////////////////////////////////////////////////////////
// Register read side

  // The buffer in flight is never offered for a new message
  assign next_free = tx_stat.active ? !tx_stat.busy_buf : !tx_stat.last_buf;

  always_comb begin
    rdat = `HDLBC_DAT_ZERO;
    case (idx)
      `HDLBC_IDX_TXCTL: begin
        rdat[`HDLBC_MODE_BIT] = st_ff.tx_mos;
      end
      `HDLBC_IDX_RXCTL: begin
        rdat[`HDLBC_MODE_BIT] = st_ff.rx_mos;
      end
      `HDLBC_IDX_TXCNT: begin
        rdat[`HDLBC_SEL_BIT] = next_free;
        rdat[`HDLBC_CNT_W-1:0] = st_ff.tx_cnt;
      end
      `HDLBC_IDX_RXCNT: begin
        rdat[`HDLBC_SEL_BIT] = rx_stat.ptr;
        rdat[`HDLBC_CNT_W-1:0] = rx_stat.len;
      end
      `HDLBC_IDX_ISTS: begin
        rdat[`HDLBC_IRQ_W-1:0] = st_ff.sts;
      end
      `HDLBC_IDX_IMSK: begin
        rdat[`HDLBC_IRQ_W-1:0] = st_ff.msk;
      end
      default: begin
        rdat = `HDLBC_DAT_ZERO;
      end
    endcase
  end

////////////////////////////////////////////////////////////////////////////////
// Register write side and interrupt

  always_comb begin
    nxt = st_ff;
    nxt.tx_start = 1'b0;
    nxt.ack = req && !st_ff.ack;
    nxt.rdat = rd_req ? rdat : `HDLBC_DAT_ZERO;
    clr = `HDLBC_IRQ_RST;
    evt = `HDLBC_IRQ_RST;
    evt[`HDLBC_IRQ_TX] = tx_stat.eot;
    evt[`HDLBC_IRQ_RX] = rx_stat.eot;
    if (wr) begin
      case (idx)
        `HDLBC_IDX_TXCTL: begin
          nxt.tx_mos = i_wb_dat[`HDLBC_MODE_BIT];
        end
        `HDLBC_IDX_RXCTL: begin
          nxt.rx_mos = i_wb_dat[`HDLBC_MODE_BIT];
        end
        `HDLBC_IDX_TXCNT: begin
          nxt.tx_sel = i_wb_dat[`HDLBC_SEL_BIT];
          nxt.tx_cnt = i_wb_dat[`HDLBC_CNT_W-1:0];
          nxt.tx_start = 1'b1;
        end
        `HDLBC_IDX_ISTS: begin
          clr = i_wb_dat[`HDLBC_IRQ_W-1:0];
        end
        `HDLBC_IDX_IMSK: begin
          nxt.msk = i_wb_dat[`HDLBC_IRQ_W-1:0];
        end
        default: begin
          clr = `HDLBC_IRQ_RST;
        end
      endcase
    end
    // A new event wins over a clear in the same cycle
    nxt.sts = (st_ff.sts & ~clr) | evt;
    nxt.irq = |(nxt.sts & nxt.msk);
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt;
    end
  end

////////////////////////////////////////////////////////////////////////////////
// Transmit and receive engines

  assign tx_cmd = '{
    start: st_ff.tx_start,
    buf_sel: st_ff.tx_sel,
    count: st_ff.tx_cnt,
    message_oriented_signalling: st_ff.tx_mos
  };

  hdlbc_tx_ctrl hdlbc_tx_ctrl_i (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_cmd(tx_cmd),
    .i_unit_done(i_tx_unit_done),
    .o_stat(tx_stat)
  );

  hdlbc_rx_ctrl hdlbc_rx_ctrl_i (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_mos(st_ff.rx_mos),
    .i_sw_wr(rx_wr),
    .i_sw_ptr(i_wb_dat[`HDLBC_SEL_BIT]),
    .i_sw_cnt(i_wb_dat[`HDLBC_CNT_W-1:0]),
    .i_evt(i_rx_evt),
    .o_stat(rx_stat)
  );

////////////////////////////////////////////////////////////////////////////////
// Outputs

  assign o_wb_dat = st_ff.rdat;
  assign o_wb_ack = st_ff.ack;
  assign o_irq = st_ff.irq;
  assign o_tx_sending = tx_stat.active;
  assign o_tx_buf = tx_stat.busy_buf;
  assign o_tx_mos = tx_stat.message_oriented_signalling;
  assign o_tx_rd_addr = tx_stat.rd_addr;
  assign o_rx_mos = st_ff.rx_mos;
  assign o_rx_ptr = rx_stat.ptr;
  assign o_rx_len = rx_stat.len;

////////////////////////////////////////////////////////////////////////////////
// Checks

  a_tx_sel_start: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n)
    (wr && idx == `HDLBC_IDX_TXCNT && !tx_stat.active)
    |-> ##2 (o_tx_sending
             && o_tx_buf == $past(i_wb_dat[`HDLBC_SEL_BIT], 2)))
    else $error("selected transmit buffer not started");

  a_tx_free_idle: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n)
    (rd_req && idx == `HDLBC_IDX_TXCNT && !tx_stat.active)
    |=> (o_wb_ack
         && o_wb_dat[`HDLBC_SEL_BIT] == !$past(tx_stat.last_buf)))
    else $error("idle read of free buffer wrong");

  a_tx_free_busy: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n)
    (rd_req && idx == `HDLBC_IDX_TXCNT && tx_stat.active)
    |=> (o_wb_ack
         && o_wb_dat[`HDLBC_SEL_BIT] != $past(tx_stat.busy_buf)))
    else $error("busy buffer offered as free");

  a_tx_mode_take: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n)
    (wr && idx == `HDLBC_IDX_TXCNT && !tx_stat.active)
    |-> ##2 (o_tx_mos == $past(st_ff.tx_mos, 1)))
    else $error("transmit mode not taken at start");

  a_tx_mos_addr: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n)
    (o_tx_sending && o_tx_mos && i_tx_unit_done && !tx_stat.eot)
    |=> (o_tx_rd_addr == $past(o_tx_rd_addr) + 16'h0001 || tx_stat.eot
         || !o_tx_sending))
    else $error("message octet address did not advance");

  a_rx_ptr_take: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n)
    i_rx_evt.done |=> (o_rx_ptr == $past(i_rx_evt.buf_ptr)))
    else $error("receive pointer not updated");

  a_rx_no_limit: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n)
    (!st_ff.rx_mos && o_rx_len == `HDLBC_CNT_ZERO && !rx_wr)
    |=> !rx_stat.eot)
    else $error("end event with zero receive count");

  a_rx_mos_len: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n)
    (i_rx_evt.done && st_ff.rx_mos)
    |=> (o_rx_len == $past(i_rx_evt.bytes) && rx_stat.eot))
    else $error("receive length not stored");

  a_rx_pair_upd: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n)
    (st_ff.rx_mos && $changed(o_rx_len) && !$past(rx_wr))
    |-> $past(i_rx_evt.done) && o_rx_ptr == $past(i_rx_evt.buf_ptr))
    else $error("receive length changed without pointer");

  a_irq_tx_raise: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n)
    (tx_stat.eot && st_ff.msk[`HDLBC_IRQ_TX]
     && !(wr && idx == `HDLBC_IDX_IMSK))
    |=> (o_irq && st_ff.sts[`HDLBC_IRQ_TX]))
    else $error("transmit end event did not interrupt");

  a_wb_ack_once: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n)
    o_wb_ack |=> !o_wb_ack)
    else $error("ack held for two cycles");

  a_wb_ack_time: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n)
    (req && !o_wb_ack) |=> o_wb_ack)
    else $error("ack not given one cycle after request");

////////////////////////////////////////////////////////////////////////////////
// Register, interrupt and transmit base address checks

  a_wb_idle_dat: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n)
    !o_wb_ack |-> o_wb_dat == `HDLBC_DAT_ZERO)
    else $error("read data outside the ack cycle");

  a_wb_rd_mask: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n)
    (rd_req && idx == `HDLBC_IDX_IMSK)
    |=> o_wb_dat[`HDLBC_IRQ_W-1:0] == $past(st_ff.msk))
    else $error("mask read back wrong");

  a_wb_rd_sts: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n)
    (rd_req && idx == `HDLBC_IDX_ISTS)
    |=> o_wb_dat[`HDLBC_IRQ_W-1:0] == $past(st_ff.sts))
    else $error("status read back wrong");

  a_wb_rd_rxcnt: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n)
    (rd_req && idx == `HDLBC_IDX_RXCNT)
    |=> (o_wb_dat[`HDLBC_SEL_BIT] == $past(o_rx_ptr)
         && o_wb_dat[`HDLBC_CNT_W-1:0] == $past(o_rx_len)))
    else $error("receive count read back wrong");

  a_tx_mode_reg: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n)
    (wr && idx == `HDLBC_IDX_TXCTL)
    |=> st_ff.tx_mos == $past(i_wb_dat[`HDLBC_MODE_BIT]))
    else $error("transmit mode bit not stored");

  a_rx_mode_reg: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n)
    (wr && idx == `HDLBC_IDX_RXCTL)
    |=> o_rx_mos == $past(i_wb_dat[`HDLBC_MODE_BIT]))
    else $error("receive mode bit not stored");

  a_tx_base_addr: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n)
    (wr && idx == `HDLBC_IDX_TXCNT && !tx_stat.active)
    |-> ##2 (o_tx_rd_addr == (o_tx_buf ? `HDLBC_BUF1_BASE : `HDLBC_BUF0_BASE)))
    else $error("transmit read not from buffer base");

  a_rx_sw_load: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n)
    (rx_wr && !i_rx_evt.done)
    |=> (o_rx_ptr == $past(i_wb_dat[`HDLBC_SEL_BIT])
         && o_rx_len == $past(i_wb_dat[`HDLBC_CNT_W-1:0])))
    else $error("receive count write not stored");

  a_rx_bos_len: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n)
    (i_rx_evt.done && !st_ff.rx_mos && !rx_wr)
    |=> $stable(o_rx_len))
    else $error("repeat count overwritten by a message");

  a_sts_tx_set: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n)
    tx_stat.eot |=> st_ff.sts[`HDLBC_IRQ_TX])
    else $error("transmit end event not latched");

  a_sts_rx_set: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n)
    rx_stat.eot |=> st_ff.sts[`HDLBC_IRQ_RX])
    else $error("receive end event not latched");

  a_sts_w1c_clear: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n)
    (wr && idx == `HDLBC_IDX_ISTS && i_wb_dat[`HDLBC_IRQ_TX] && !tx_stat.eot)
    |=> !st_ff.sts[`HDLBC_IRQ_TX])
    else $error("transmit status not cleared by a one");

  a_irq_rx_raise: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n)
    (rx_stat.eot && st_ff.msk[`HDLBC_IRQ_RX]
     && !(wr && idx == `HDLBC_IDX_IMSK))
    |=> (o_irq && st_ff.sts[`HDLBC_IRQ_RX]))
    else $error("receive end event did not interrupt");

  a_irq_masked_off: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n)
    (st_ff.msk == `HDLBC_IRQ_RST) |-> !o_irq)
    else $error("interrupt raised while fully masked");

endmodule : hdlbc_top

// [hdl/hdlbc_tx_ctrl.sv]
// Transmit buffer sequencing and octet or repetition counting
`timescale 1ns/1ps
`include "hdlbc_cfg.svh"
module hdlbc_tx_ctrl (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_n,
  // Command and link
  input wire hdlbc_pkg::hdlbc_tx_cmd_s i_cmd,
  input wire logic i_unit_done,
  // Status
  output hdlbc_pkg::hdlbc_tx_stat_s o_stat
);
  hdlbc_pkg::hdlbc_tx_st_s st_ff, nxt;
  logic launch, l_buf, l_mos;
  hdlbc_pkg::hdlbc_cnt_t l_cnt;
  always_comb begin
    nxt = st_ff;
    launch = 1'b0;
    l_buf = st_ff.pend_buf;
    l_cnt = st_ff.pend_cnt;
    l_mos = st_ff.pend_mos;
    unique case (st_ff.fsm)
      hdlbc_pkg::TX_IDLE: begin
        // A start queued during the done cycle is launched here, not lost
        launch = st_ff.pend;
        nxt.pend = 1'b0;
      end
      hdlbc_pkg::TX_RUN: begin
        if (i_unit_done) begin
          nxt.sent = st_ff.sent + `HDLBC_CNT_ONE;
          if (st_ff.infinite && st_ff.pend) begin
            launch = 1'b1;
            nxt.pend = 1'b0;
          end else if (!st_ff.infinite && nxt.sent == st_ff.cnt) begin
            nxt.fsm = hdlbc_pkg::TX_DONE;
          end
        end
      end
      hdlbc_pkg::TX_DONE: begin
        nxt.last_buf = st_ff.busy_buf;
        nxt.fsm = hdlbc_pkg::TX_IDLE;
        launch = st_ff.pend;
        nxt.pend = 1'b0;
      end
    endcase
    if (i_cmd.start && st_ff.fsm == hdlbc_pkg::TX_IDLE) begin
      launch = 1'b1;
      l_buf = i_cmd.buf_sel;
      l_cnt = i_cmd.count;
      l_mos = i_cmd.message_oriented_signalling;
    end else if (i_cmd.start && i_cmd.buf_sel != st_ff.busy_buf) begin
      nxt.pend = 1'b1;
      nxt.pend_buf = i_cmd.buf_sel;
      nxt.pend_cnt = i_cmd.count;
      nxt.pend_mos = i_cmd.message_oriented_signalling;
    end
    if (launch) begin
      nxt.fsm = (l_mos && l_cnt == `HDLBC_CNT_ZERO) ? hdlbc_pkg::TX_DONE : hdlbc_pkg::TX_RUN;
      nxt.busy_buf = l_buf;
      nxt.cnt = l_cnt;
      nxt.sent = `HDLBC_CNT_ZERO;
      nxt.message_oriented_signalling = l_mos;
      nxt.infinite = !l_mos && l_cnt == `HDLBC_CNT_ZERO;
    end
    nxt.active = nxt.fsm != hdlbc_pkg::TX_IDLE;
    nxt.rd_addr = (nxt.busy_buf ? `HDLBC_BUF1_BASE : `HDLBC_BUF0_BASE) + {`HDLBC_ADR_PAD, nxt.sent};
  end
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt;
    end
  end
  assign o_stat = '{active: st_ff.active, busy_buf: st_ff.busy_buf, last_buf: st_ff.last_buf,
                    eot: st_ff.fsm == hdlbc_pkg::TX_DONE, message_oriented_signalling: st_ff.message_oriented_signalling, rd_addr: st_ff.rd_addr};
  a_tx_count_end: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n)
    (st_ff.fsm == hdlbc_pkg::TX_RUN && i_unit_done && !st_ff.infinite
     && st_ff.sent + `HDLBC_CNT_ONE == st_ff.cnt) |=> o_stat.eot ##1 !o_stat.eot)
    else $error("tx count reached without end event");
  a_tx_no_limit: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n)
    (st_ff.infinite && st_ff.fsm == hdlbc_pkg::TX_RUN && !(i_unit_done && st_ff.pend))
    |=> !o_stat.eot)
    else $error("unlimited repetition ended");
endmodule : hdlbc_tx_ctrl
